// ### verilog/rst_cfg.svh
/*
 * constants for the reset supervisor: command pattern, pulse qualify
 * counts and default control byte settings. assumes a 200 MHz ref_clk.
 */
`ifndef RST_CFG_SVH
`define RST_CFG_SVH
`define CLK_PERIOD_PS     5000
`define PIN_MIN_NS        200
`define PIN_MIN_CYC       ((`PIN_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SWRST_MASK        8'hfc
`define SWRST_CODE        8'hb4
`define CTRL_DEFAULT      8'h00
`define POR_HOLD_CYC      16
`define RAMP_OK_CYC       8
`define SYNC_STAGES       2
`endif

// ### verilog/rst_pkg.sv
/*
 * types for the reset supervisor.
 * assumes rst_cfg.svh is included by the design files.
 */
package rst_pkg;
    typedef enum logic [3:0] {
        ST_POR  = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_REL  = 4'b1000
    } rst_state_t;
    typedef logic [7:0] ctrl_byte_t;
endpackage : rst_pkg

// ### verilog/sync_if.sv
/*
 * interface carrying a level between the supervisor and its synchroniser.
 * assumes one clock domain, ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface sync_if;
    logic rawIn;
    logic syncOut;
    modport src (output rawIn, input syncOut);
    modport dst (input rawIn, output syncOut);
endinterface : sync_if
`default_nettype wire

// ### verilog/level_sync.sv
/*
 * two-flop level synchroniser, reset to active (asserted) state.
 * assumes ref_clk and asynchronous active-low rst_n.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_cfg.svh"
module level_sync (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    sync_if.dst       port
);
    typedef struct packed {
        logic [`SYNC_STAGES-1:0] stage;
    } sync_state_t;
    sync_state_t state_r;
    sync_state_t state_nxt;
    // shift raw level through the chain
    always_comb begin
        state_nxt.stage = {state_r.stage[`SYNC_STAGES-2:0], port.rawIn};
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '1;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign port.syncOut = state_r.stage[`SYNC_STAGES-1];
endmodule : level_sync
`default_nettype wire

// ### verilog/reset_supervisor_logic.sv
/*
 * reset supervisor merging pin, software and power-on resets into one
 * internal reset and restoring the control byte default.
 * assumes ref_clk at 200 MHz, a decoded command byte strobe from the
 * serial interface, and a supply-good level from the analog ramp monitor.
 */
`timescale 1ns/100ps
`default_nettype none
`include "rst_cfg.svh"
module reset_supervisor_logic
    import rst_pkg::*;
#(
    parameter int PIN_MIN = `PIN_MIN_CYC,
    parameter int POR_HOLD = `POR_HOLD_CYC,
    parameter int RAMP_OK = `RAMP_OK_CYC
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               resetPin_n,
    input  wire logic               supplyRising,
    input  wire logic               cmdValid,
    input  wire logic [7:0]         cmdByte,
    input  wire logic               ctrlWrite,
    input  wire rst_pkg::ctrl_byte_t ctrlIn,
    output logic                    sysReset,
    output rst_pkg::ctrl_byte_t     ctrlByte,
    output logic                    swResetSeen,
    output logic                    porDone
);
    import rst_pkg::*;

    localparam int CW = 8;

    typedef struct packed {
        rst_state_t  st;
        logic [CW-1:0] cnt;
        logic [CW-1:0] pinCnt;
        logic [CW-1:0] rampCnt;
        ctrl_byte_t  ctrl;
        logic        swSeen;
        logic        porOk;
        logic        reset;
    } sup_state_t;

    sup_state_t s_r;
    sup_state_t s_nxt;
    sync_if     pinSync ();
    logic       pinLow;
    logic       swHit;

    // pattern match on the setup command, two low bits ignored
    function automatic logic is_sw_reset(input logic [7:0] b);
        is_sw_reset = (b & `SWRST_MASK) == `SWRST_CODE;
    endfunction : is_sw_reset

    // pin is asynchronous to ref_clk
    assign pinSync.rawIn = ~resetPin_n;
    level_sync u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .port    (pinSync)
    );
    assign pinLow = pinSync.syncOut;
    assign swHit = cmdValid && is_sw_reset(cmdByte);

    // sequencing of the merged reset
    always_comb begin
        s_nxt = s_r;
        // pulse width counter on the pin; shorter pulses may be missed
        s_nxt.pinCnt = pinLow ? ((s_r.pinCnt == CW'(PIN_MIN)) ? s_r.pinCnt
                      : s_r.pinCnt + CW'(1)) : '0;
        case (s_r.st)
            ST_POR: begin
                // ramp must rise for RAMP_OK + 1 cycles in a row before release
                s_nxt.reset = 1'b1;
                s_nxt.ctrl = `CTRL_DEFAULT;
                if (supplyRising) begin
                    s_nxt.rampCnt = s_r.rampCnt + CW'(1);
                end else begin
                    s_nxt.rampCnt = '0;
                end
                // a break in the ramp on the last cycle still blocks release
                if (supplyRising && s_r.rampCnt == CW'(RAMP_OK)) begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cnt = '0;
                    s_nxt.porOk = 1'b1;
                end
            end
            ST_HOLD: begin
                s_nxt.reset = 1'b1;
                s_nxt.ctrl = `CTRL_DEFAULT;
                s_nxt.cnt = s_r.cnt + CW'(1);
                if (pinLow) begin
                    s_nxt.cnt = '0;
                end else if (s_r.cnt == CW'(POR_HOLD)) begin
                    s_nxt.st = ST_REL;
                end
            end
            ST_REL: begin
                s_nxt.reset = 1'b0;
                s_nxt.st = ST_RUN;
            end
            ST_RUN: begin
                s_nxt.reset = 1'b0;
                if (ctrlWrite) begin
                    s_nxt.ctrl = ctrlIn;
                end
                if (s_r.pinCnt == CW'(PIN_MIN)) begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cnt = '0;
                    s_nxt.reset = 1'b1;
                    s_nxt.ctrl = `CTRL_DEFAULT;
                end else if (swHit) begin
                    s_nxt.st = ST_HOLD;
                    s_nxt.cnt = '0;
                    s_nxt.reset = 1'b1;
                    s_nxt.swSeen = 1'b1;
                    s_nxt.ctrl = `CTRL_DEFAULT;
                end
            end
            default: begin
                s_nxt.st = ST_POR;
                s_nxt.reset = 1'b1;
            end
        endcase
    end

    // state register, power-on state forced by rst_n
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.st <= ST_POR;
            s_r.cnt <= '0;
            s_r.pinCnt <= '0;
            s_r.rampCnt <= '0;
            s_r.ctrl <= `CTRL_DEFAULT;
            s_r.swSeen <= 1'b0;
            s_r.porOk <= 1'b0;
            s_r.reset <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sysReset = s_r.reset;
    assign ctrlByte = s_r.ctrl;
    assign swResetSeen = s_r.swSeen;
    assign porDone = s_r.porOk;

    // checks
    AST_PIN_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_RUN && s_r.pinCnt == CW'(PIN_MIN))
        |=> sysReset && ctrlByte == `CTRL_DEFAULT)
        else $error("pin reset not taken");
    AST_PIN_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(s_r.pinCnt == CW'(PIN_MIN)) && s_r.st == ST_RUN
        |=> ctrlByte == `CTRL_DEFAULT)
        else $error("control byte not defaulted on pin reset");
    AST_SW_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_RUN && swHit && s_r.pinCnt != CW'(PIN_MIN))
        |=> sysReset && swResetSeen)
        else $error("software reset not taken");
    AST_SW_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_RUN && swHit) |=> ctrlByte == `CTRL_DEFAULT)
        else $error("control byte not defaulted on software reset");
    AST_NO_FALSE_SW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_RUN && cmdValid
         && (cmdByte & `SWRST_MASK) != `SWRST_CODE
         && !pinLow && s_r.pinCnt == '0) |=> !sysReset)
        else $error("reset from a non-reset command");
    AST_POR_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !porDone |-> sysReset)
        else $error("released before power-on reset done");
    AST_RAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_POR && !supplyRising) |=> s_r.st == ST_POR)
        else $error("power-on left without a clean ramp");
    AST_HOLD_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(sysReset) |-> $past(sysReset, POR_HOLD + 2))
        else $error("merged reset too short");
    AST_RUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_r.st == ST_RUN && !pinLow && !swHit
         && s_r.pinCnt != CW'(PIN_MIN)) |=> !sysReset)
        else $error("reset without qualified source");
    COV_POR: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(porDone));
    COV_PIN: cover property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.st == ST_RUN && s_r.pinCnt == CW'(PIN_MIN));
    COV_SW: cover property (@(posedge ref_clk) disable iff (!rst_n)
        s_r.st == ST_RUN && swHit);
endmodule : reset_supervisor_logic
`default_nettype wire

// ### testbench/host_model.sv
/*
 * host and supply model: reset pin, setup bytes, control writes, ramp.
 * assumes ref_clk of the supervisor; drives on its rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic          ref_clk,
    output logic               resetPin_n,
    output logic               supplyRising,
    output logic               cmdValid,
    output logic [7:0]         cmdByte,
    output logic               ctrlWrite,
    output rst_pkg::ctrl_byte_t ctrlIn
);
    // idle levels; data lines never hold a stale byte
    initial begin
        resetPin_n = 1'b1;
        supplyRising = 1'b0;
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        ctrlWrite = 1'b0;
        ctrlIn = 8'hff;
    end
    // one setup byte, valid for a single cycle
    task send_cmd(input logic [7:0] b);
        @(posedge ref_clk) cmdValid <= 1'b1;
        cmdByte <= b;
        @(posedge ref_clk) cmdValid <= 1'b0;
        cmdByte <= ~b;
    endtask : send_cmd
    // load a control byte value
    task write_ctrl(input logic [7:0] v);
        @(posedge ref_clk) ctrlWrite <= 1'b1;
        ctrlIn <= v;
        @(posedge ref_clk) ctrlWrite <= 1'b0;
        ctrlIn <= ~v;
    endtask : write_ctrl
    // pin held low for n cycles; runts below the minimum are ignored
    task pin_pulse(input int n);
        @(posedge ref_clk) resetPin_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        resetPin_n <= 1'b1;
    endtask : pin_pulse
    // supply ramp level
    task ramp(input logic up);
        @(posedge ref_clk) supplyRising <= up;
    endtask : ramp
endmodule : host_model
`default_nettype wire

// ### testbench/touch_ctrl_reset_logic_tb_top.sv
/*
 * self-checking bench for reset_supervisor_logic with short counts.
 * assumes the host_model partner drives the far-side inputs.
 */
`timescale 1ns/100ps
`default_nettype none
module touch_ctrl_reset_logic_tb_top;
    localparam int PMIN = 4;
    localparam int PHOLD = 2;
    typedef struct packed {logic [7:0] cmd; logic rst;} row_t;
    row_t rows [8] = '{'{8'hb4, 1'b1}, '{8'hb5, 1'b1}, '{8'hb6, 1'b1},
        '{8'hb7, 1'b1}, '{8'hb0, 1'b0}, '{8'hb8, 1'b0},
        '{8'hf4, 1'b0}, '{8'h34, 1'b0}};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic resetPin_n, supplyRising, cmdValid, ctrlWrite;
    logic [7:0] cmdByte;
    rst_pkg::ctrl_byte_t ctrlIn, ctrlByte;
    logic sysReset, swResetSeen, porDone;
    int errors = 0;
    int tests_run = 0;
    int n;
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    host_model host (.ref_clk(ref_clk), .resetPin_n(resetPin_n),
        .supplyRising(supplyRising), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .ctrlWrite(ctrlWrite), .ctrlIn(ctrlIn));
    reset_supervisor_logic #(.PIN_MIN(PMIN), .POR_HOLD(PHOLD),
        .RAMP_OK(2)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .resetPin_n(resetPin_n), .supplyRising(supplyRising),
        .cmdValid(cmdValid), .cmdByte(cmdByte), .ctrlWrite(ctrlWrite),
        .ctrlIn(ctrlIn), .sysReset(sysReset), .ctrlByte(ctrlByte),
        .swResetSeen(swResetSeen), .porDone(porDone));
    // comparisons
    task chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // cycles until internal reset releases, bounded
    task wait_rel;
        n = 0;
        while (sysReset !== 1'b0 && n < 300) begin
            @(posedge ref_clk) #1 n++;
        end
        if (n >= 300) begin
            errors++;
            $display("Error at %0t: reset never released", $time);
            wrap_up;
        end
    endtask : wait_rel
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 chk1(sysReset, 1'b1);
        chk8(ctrlByte, 8'h00);
        @(posedge ref_clk) rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 chk1(sysReset, 1'b1);
        chk1(porDone, 1'b0);
        host.ramp(1'b1);
        wait_rel;
        chk1(porDone, 1'b1);
        chk1(swResetSeen, 1'b0);
        foreach (rows[i]) begin
            host.write_ctrl(8'h5a);
            host.send_cmd(rows[i].cmd);
            #1 chk1(sysReset, rows[i].rst);
            chk8(ctrlByte, rows[i].rst ? 8'h00 : 8'h5a);
            if (rows[i].rst) begin
                wait_rel;
                chk1(logic'(n == PHOLD + 2), 1'b1);
            end
        end
        // runt pulse on the pin is ignored
        host.pin_pulse(1);
        repeat (4) @(posedge ref_clk);
        #1 chk1(sysReset, 1'b0);
        // pin reset, pulse well over the minimum width
        host.write_ctrl(8'h3c);
        host.pin_pulse(3 * PMIN);
        #1 chk1(sysReset, 1'b1);
        chk8(ctrlByte, 8'h00);
        // control write during the hold is refused
        host.write_ctrl(8'hc3);
        #1 chk8(ctrlByte, 8'h00);
        wait_rel;
        chk8(ctrlByte, 8'h00);
        chk1(swResetSeen, 1'b1);
        // power-on reset again in mid-run
        host.write_ctrl(8'h77);
        @(posedge ref_clk) rst_n <= 1'b0;
        @(posedge ref_clk) #1 chk8(ctrlByte, 8'h00);
        chk1(swResetSeen, 1'b0);
        @(posedge ref_clk) rst_n <= 1'b1;
        wait_rel;
        chk1(porDone, 1'b1);
        wrap_up;
    end
endmodule : touch_ctrl_reset_logic_tb_top
`default_nettype wire
